/* oled_ctl_regs.svh */
`ifndef OLED_CTL_REGS_SVH
`define OLED_CTL_REGS_SVH

// Interface and timing constants for the display power/init controller.
`define CLK_PERIOD_PS 8000
`define I2C_TARGET_ADDR 7'h30
`define VDD_WAIT_MS 100
`define HV_SETTLE_US 1
`define RST_WAIT_PS 1000000
`define RST_REL_WAIT_PS 100000
`define DISP_ON_WAIT_US 1100
`define VDD_WAIT_CYC (`VDD_WAIT_MS * 1000000 / (`CLK_PERIOD_PS / 1000))
`define RST_WAIT_CYC ((`RST_WAIT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RST_REL_CYC ((`RST_REL_WAIT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DISP_ON_CYC (`DISP_ON_WAIT_US * 1000000 / `CLK_PERIOD_PS + 1)
`define HV_SETTLE_CYC 125000
`define INIT_LEN 23
`define IMG_BYTES 256
`define SCK_DIV 8

`endif

/* oled_ctl_pkg.sv */
package oled_ctl_pkg;

    // One byte to send: cmd_data_select level and the byte itself.
    typedef struct packed {
        logic is_data;
        logic [7:0] value;
    } link_byte_t;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_POWER_UP,
        OP_INIT,
        OP_DISPLAY_ON,
        OP_DISPLAY_OFF,
        OP_POWER_DOWN
    } op_t;

    typedef struct packed {
        logic vdd_en;
        logic hv_en;
        logic reset_n;
        logic chip_select_n;
    } power_pins_t;

endpackage

/* serial_byte_tx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oled_ctl_regs.svh"

module serial_byte_tx #(
    parameter int DIV = `SCK_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic host_if_select,
    input wire logic start,
    input wire oled_ctl_pkg::link_byte_t byte_in,
    input wire logic link_clk_in,
    input wire logic link_data_in,
    output logic busy,
    output logic nack,
    output logic sck,
    output logic sck_oe_n,
    output logic sda,
    output logic sda_oe_n,
    output logic cds
);
    import oled_ctl_pkg::*;

    // Bit pulse from a divider; each bit spans four phase ticks.
    logic [$clog2(DIV)-1:0] div_r;
    logic tick;
    logic [1:0] ph_r;
    logic [5:0] bit_r;
    logic [26:0] sh_r;
    logic [5:0] nbits_r;
    logic ack_s1_r, ack_s2_r;

    assign tick = (div_r == '0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // Returned acknowledge bit is an outside pin; synchronise it first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_s1_r <= 1'b1;
            ack_s2_r <= 1'b1;
        end else begin
            ack_s1_r <= link_data_in;
            ack_s2_r <= ack_s1_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            nack <= 1'b0;
            ph_r <= 2'h0;
            bit_r <= 6'h0;
            sh_r <= '0;
            nbits_r <= 6'h0;
            sck <= 1'b1;
            sda <= 1'b1;
            sck_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            cds <= 1'b0;
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                nack <= 1'b0;
                ph_r <= 2'h0;
                bit_r <= 6'h0;
                cds <= byte_in.is_data;
                sck_oe_n <= 1'b0;
                sda_oe_n <= 1'b0;
                if (host_if_select) begin
                    // address frame 0110000b write, control byte, data.
                    sh_r <= {`I2C_TARGET_ADDR, 1'b0, 1'b1,
                             ~byte_in.is_data, 7'h00, 1'b1,
                             byte_in.value, 1'b1};
                    nbits_r <= 6'd27;
                    sda <= 1'b0;
                end else begin
                    sh_r <= {byte_in.value, 19'h0};
                    nbits_r <= 6'd8;
                    sck <= 1'b0;
                end
            end
        end else if (tick) begin
            ph_r <= ph_r + 2'h1;
            if (bit_r == nbits_r) begin
                // Closing phase: stop condition for I2C, idle for SPI.
                case (ph_r)
                    2'h0: begin
                        sck <= host_if_select ? 1'b0 : 1'b1;
                        sda <= 1'b0;
                        sda_oe_n <= 1'b0;
                    end
                    2'h1: sck <= 1'b1;
                    2'h2: sda <= 1'b1;
                    default: begin
                        busy <= 1'b0;
                        sck_oe_n <= 1'b1;
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end else begin
                case (ph_r)
                    2'h0: begin
                        sck <= 1'b0;
                        sda <= sh_r[26];
                        // Acknowledge slots release the data line.
                        sda_oe_n <= host_if_select &&
                            (bit_r == 6'd8 || bit_r == 6'd17 ||
                             bit_r == 6'd26);
                    end
                    2'h1: sck <= 1'b1;
                    2'h2: begin
                        if (!sda_oe_n) begin
                            sh_r <= {sh_r[25:0], 1'b0};
                        end else begin
                            sh_r <= {sh_r[25:0], 1'b0};
                            if (ack_s2_r) begin
                                nack <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        // SPI keeps the clock high between bits, so the
                        // return to idle adds no sampling edge.
                        sck <= !host_if_select;
                        bit_r <= bit_r + 6'h1;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* wait_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module wait_timer #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign done = (cnt_r == '0) && !load;

endmodule

`default_nettype wire

/* display_power_init_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "oled_ctl_regs.svh"

module display_power_init_sequencer #(
    parameter int VDD_WAIT = `VDD_WAIT_CYC,
    parameter int HV_SETTLE = `HV_SETTLE_CYC,
    parameter int DISP_ON_WAIT = `DISP_ON_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire oled_ctl_pkg::op_t op,
    input wire logic op_valid,
    input wire logic with_image,
    input wire logic [7:0] img_byte,
    input wire logic host_if_select,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    output logic op_ready,
    output logic op_error,
    output logic img_req,
    output oled_ctl_pkg::power_pins_t pins,
    output logic cmd_data_select,
    output logic serial_clock_pin,
    output logic serial_clock_oe_n,
    output logic serial_data_pin,
    output logic serial_data_oe_n,
    output logic powered,
    output logic shown
);
    import oled_ctl_pkg::*;

    typedef enum {
        S_OFF, S_UP_VDD, S_UP_CS, S_UP_HV, S_UP_RST, S_READY,
        S_SEND, S_SEND_WAIT, S_ON_WAIT,
        S_DN_CS, S_DN_RST, S_DN_HV, S_DN_CS_LO
    } state_t;

    // Init table: command bytes have is_data low, parameters high.
    function automatic link_byte_t init_rom(input logic [5:0] i);
        case (i)
            6'd0: init_rom = '{1'b0, 8'h02};
            6'd1: init_rom = '{1'b1, 8'h00};
            6'd2: init_rom = '{1'b0, 8'h14};
            6'd3: init_rom = '{1'b1, 8'h01};
            6'd4: init_rom = '{1'b0, 8'h1A};
            6'd5: init_rom = '{1'b1, 8'h04};
            6'd6: init_rom = '{1'b0, 8'h1D};
            6'd7: init_rom = '{1'b1, 8'h00};
            6'd8: init_rom = '{1'b0, 8'h09};
            6'd9: init_rom = '{1'b1, 8'h00};
            6'd10: init_rom = '{1'b0, 8'h30};
            6'd11: init_rom = '{1'b1, 8'h00};
            6'd12: init_rom = '{1'b1, 8'h3B};
            6'd13: init_rom = '{1'b0, 8'h32};
            6'd14: init_rom = '{1'b1, 8'h00};
            6'd15: init_rom = '{1'b1, 8'h1F};
            6'd16: init_rom = '{1'b0, 8'h38};
            6'd17: init_rom = '{1'b1, 8'h00};
            6'd18: init_rom = '{1'b0, 8'h39};
            6'd19: init_rom = '{1'b1, 8'h00};
            6'd20: init_rom = '{1'b0, 8'h34};
            6'd21: init_rom = '{1'b1, 8'h00};
            6'd22: init_rom = '{1'b0, 8'h35};
            6'd23: init_rom = '{1'b1, 8'h07};
            6'd24: init_rom = '{1'b0, 8'h36};
            6'd25: init_rom = '{1'b1, 8'h00};
            6'd26: init_rom = '{1'b0, 8'h37};
            6'd27: init_rom = '{1'b1, 8'h1F};
            6'd28: init_rom = '{1'b0, 8'h10};
            6'd29: init_rom = '{1'b1, 8'h00};
            6'd30: init_rom = '{1'b0, 8'h16};
            6'd31: init_rom = '{1'b1, 8'h00};
            6'd32: init_rom = '{1'b0, 8'h12};
            6'd33: init_rom = '{1'b1, 8'h50};
            6'd34: init_rom = '{1'b0, 8'h18};
            6'd35: init_rom = '{1'b1, 8'h03};
            6'd36: init_rom = '{1'b0, 8'h44};
            6'd37: init_rom = '{1'b1, 8'h02};
            6'd38: init_rom = '{1'b0, 8'h48};
            6'd39: init_rom = '{1'b1, 8'h03};
            6'd40: init_rom = '{1'b0, 8'h17};
            6'd41: init_rom = '{1'b1, 8'h00};
            6'd42: init_rom = '{1'b0, 8'h13};
            6'd43: init_rom = '{1'b1, 8'h00};
            6'd44: init_rom = '{1'b0, 8'h1C};
            default: init_rom = '{1'b1, 8'h00};
        endcase
    endfunction

    localparam logic [5:0] INIT_LAST = 6'd46;

    state_t state_r;
    op_t cur_op_r;
    logic [8:0] idx_r;
    logic [8:0] last_r;
    logic img_r;
    logic [2:0] phase_r;
    logic start_r;
    link_byte_t byte_r;
    logic tx_busy, tx_nack, tx_sck, tx_sck_oe_n, tx_sda, tx_sda_oe_n, tx_cds;
    logic t_load;
    logic [23:0] t_count;
    logic t_done;
    logic on_ok_load, on_ok;
    logic ck_s1_r, ck_s2_r;

    // Clock line sense is synchronised and handed to the sender, which never reads it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ck_s1_r <= 1'b1;
            ck_s2_r <= 1'b1;
        end else begin
            ck_s1_r <= serial_clock_in;
            ck_s2_r <= ck_s1_r;
        end
    end

    serial_byte_tx u_tx (
        .clk(clk),
        .rst(rst),
        .host_if_select(host_if_select),
        .start(start_r),
        .byte_in(byte_r),
        .link_clk_in(ck_s2_r),
        .link_data_in(serial_data_in),
        .busy(tx_busy),
        .nack(tx_nack),
        .sck(tx_sck),
        .sck_oe_n(tx_sck_oe_n),
        .sda(tx_sda),
        .sda_oe_n(tx_sda_oe_n),
        .cds(tx_cds)
    );

    wait_timer #(.W(24)) u_wait (
        .clk(clk),
        .rst(rst),
        .load(t_load),
        .count(t_count),
        .done(t_done)
    );

    // Separate timer so the display-on guard runs across the init op.
    wait_timer #(.W(24)) u_on_guard (
        .clk(clk),
        .rst(rst),
        .load(on_ok_load),
        .count(24'(DISP_ON_WAIT)),
        .done(on_ok)
    );

    always_comb begin
        t_load = 1'b0;
        t_count = 24'h0;
        on_ok_load = 1'b0;
        case (state_r)
            S_UP_VDD: begin
                t_load = (phase_r == 3'h0);
                t_count = 24'(VDD_WAIT);
            end
            S_UP_HV: begin
                t_load = (phase_r == 3'h0);
                t_count = 24'(HV_SETTLE + `RST_WAIT_CYC);
            end
            S_UP_RST: begin
                t_load = (phase_r == 3'h0);
                t_count = 24'(`RST_REL_CYC);
                on_ok_load = (phase_r == 3'h0);
            end
            S_DN_RST: begin
                t_load = (phase_r == 3'h0);
                t_count = 24'(`RST_WAIT_CYC);
            end
            S_DN_HV: begin
                t_load = (phase_r == 3'h0);
                t_count = 24'(HV_SETTLE);
            end
            default: begin
                t_load = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= S_OFF;
            cur_op_r <= OP_NONE;
            phase_r <= 3'h0;
            idx_r <= 9'h0;
            last_r <= 9'h0;
            img_r <= 1'b0;
            start_r <= 1'b0;
            byte_r <= '0;
            op_ready <= 1'b0;
            op_error <= 1'b0;
            img_req <= 1'b0;
            pins <= '{1'b0, 1'b0, 1'b0, 1'b0};
            powered <= 1'b0;
            shown <= 1'b0;
        end else begin
            start_r <= 1'b0;
            img_req <= 1'b0;
            phase_r <= (phase_r == 3'h0) ? 3'h1 : phase_r;
            case (state_r)
                S_OFF: begin
                    op_ready <= 1'b1;
                    if (op_valid && op == OP_POWER_UP) begin
                        op_ready <= 1'b0;
                        op_error <= 1'b0;
                        pins.vdd_en <= 1'b1;
                        state_r <= S_UP_VDD;
                        phase_r <= 3'h0;
                    end
                end
                S_UP_VDD: if (phase_r != 3'h0 && t_done) begin
                    pins.chip_select_n <= 1'b1;
                    state_r <= S_UP_CS;
                end
                S_UP_CS: begin
                    pins.hv_en <= 1'b1;
                    state_r <= S_UP_HV;
                    phase_r <= 3'h0;
                end
                S_UP_HV: if (phase_r != 3'h0 && t_done) begin
                    pins.reset_n <= 1'b1;
                    powered <= 1'b1;
                    state_r <= S_UP_RST;
                    phase_r <= 3'h0;
                end
                S_UP_RST: if (phase_r != 3'h0 && t_done) begin
                    state_r <= S_READY;
                end
                S_READY: begin
                    op_ready <= 1'b1;
                    // Chip select stays low from the first byte until the op's last byte ends, as I2C needs.
                    if (op_valid) begin
                        op_ready <= 1'b0;
                        op_error <= 1'b0;
                        cur_op_r <= op;
                        idx_r <= 9'h0;
                        img_r <= with_image;
                        case (op)
                            OP_INIT: begin
                                last_r <= {3'h0, INIT_LAST};
                                state_r <= S_SEND;
                            end
                            OP_DISPLAY_ON: begin
                                last_r <= with_image ?
                                    9'(`IMG_BYTES + 5) : 9'd4;
                                state_r <= S_ON_WAIT;
                            end
                            OP_DISPLAY_OFF: begin
                                last_r <= 9'd4;
                                state_r <= S_SEND;
                            end
                            OP_POWER_DOWN: begin
                                state_r <= S_DN_CS;
                            end
                            default: begin
                                op_error <= 1'b1;
                                op_ready <= 1'b1;
                            end
                        endcase
                    end
                end
                S_ON_WAIT: if (on_ok) begin
                    state_r <= S_SEND;
                end
                S_SEND: begin
                    pins.chip_select_n <= 1'b0;
                    start_r <= 1'b1;
                    state_r <= S_SEND_WAIT;
                    case (cur_op_r)
                        OP_INIT: byte_r <= init_rom(idx_r[5:0]);
                        OP_DISPLAY_OFF: begin
                            // Display off then standby on state.
                            case (idx_r[1:0])
                                2'h0: byte_r <= '{1'b0, 8'h02};
                                2'h1: byte_r <= '{1'b1, 8'h00};
                                2'h2: byte_r <= '{1'b0, 8'h14};
                                default: byte_r <= '{1'b1, 8'h01};
                            endcase
                        end
                        default: begin
                            if (idx_r == 9'd0) begin
                                byte_r <= '{1'b0, 8'h14};
                            end else if (idx_r == 9'd1) begin
                                byte_r <= '{1'b1, 8'h00};
                            end else if (img_r && idx_r == 9'd2) begin
                                byte_r <= '{1'b0, 8'h08};
                            end else if (idx_r == last_r - 9'd2) begin
                                byte_r <= '{1'b0, 8'h02};
                            end else if (idx_r == last_r - 9'd1) begin
                                byte_r <= '{1'b1, 8'h01};
                            end else begin
                                byte_r <= '{1'b1, img_byte};
                                img_req <= 1'b1;
                            end
                        end
                    endcase
                end
                S_SEND_WAIT: if (!start_r && !tx_busy) begin
                    op_error <= op_error | tx_nack;
                    idx_r <= idx_r + 9'h1;
                    if (idx_r + 9'h1 == last_r) begin
                        if (cur_op_r == OP_DISPLAY_ON) begin
                            shown <= 1'b1;
                        end else if (cur_op_r == OP_DISPLAY_OFF) begin
                            shown <= 1'b0;
                        end
                        pins.chip_select_n <= 1'b1;
                        state_r <= S_READY;
                    end else begin
                        state_r <= S_SEND;
                    end
                end
                S_DN_CS: begin
                    pins.chip_select_n <= 1'b1;
                    state_r <= S_DN_RST;
                    phase_r <= 3'h0;
                end
                S_DN_RST: begin
                    pins.reset_n <= 1'b0;
                    if (phase_r != 3'h0 && t_done) begin
                        pins.hv_en <= 1'b0;
                        state_r <= S_DN_HV;
                        phase_r <= 3'h0;
                    end
                end
                S_DN_HV: if (phase_r != 3'h0 && t_done) begin
                    pins.chip_select_n <= 1'b0;
                    state_r <= S_DN_CS_LO;
                end
                S_DN_CS_LO: begin
                    pins.vdd_en <= 1'b0;
                    powered <= 1'b0;
                    shown <= 1'b0;
                    state_r <= S_OFF;
                end
                default: state_r <= S_OFF;
            endcase
        end
    end

    // Data/clock lines are released outside traffic, as needs.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_data_select <= 1'b0;
            serial_clock_pin <= 1'b1;
            serial_clock_oe_n <= 1'b1;
            serial_data_pin <= 1'b1;
            serial_data_oe_n <= 1'b1;
        end else begin
            cmd_data_select <= tx_busy ? tx_cds : 1'b0;
            serial_clock_pin <= tx_sck;
            serial_clock_oe_n <= tx_sck_oe_n;
            serial_data_pin <= tx_sda;
            serial_data_oe_n <= tx_sda_oe_n;
        end
    end

endmodule

`default_nettype wire

/* seq_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module seq_properties #(
    parameter int VDD_WAIT = 100,
    parameter int HV_SETTLE = 50,
    parameter int DISP_ON_WAIT = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire oled_ctl_pkg::power_pins_t pins,
    input wire logic cmd_data_select,
    input wire logic serial_clock_pin,
    input wire logic serial_clock_oe_n,
    input wire logic serial_data_oe_n,
    input wire logic shown
);
    import oled_ctl_pkg::*;
    localparam int VW = VDD_WAIT + 4;
    int hv_cnt;
    int up_cnt;
    int lo_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Run lengths count the cycles since each level was last entered.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hv_cnt <= 0;
            up_cnt <= 0;
            lo_cnt <= 0;
        end else begin
            hv_cnt <= pins.hv_en ? hv_cnt + 1 : 0;
            up_cnt <= pins.reset_n ? up_cnt + 1 : 0;
            lo_cnt <= pins.reset_n ? 0 : lo_cnt + 1;
        end
    end
    sequence vdd_on;
        $rose(pins.vdd_en) && !pins.chip_select_n;
    endsequence
    sequence cs_off;
        $rose(pins.chip_select_n) && !pins.hv_en;
    endsequence
    vdd_wait_a: assert property (vdd_on |-> ##[1:VW] cs_off)
        else $error("select late");
    supply_quiet_a: assert property ($changed(pins.vdd_en) |->
        !pins.reset_n && !pins.chip_select_n && !cmd_data_select
        && serial_clock_oe_n && serial_data_oe_n) else $error("pins busy");
    hv_order_a: assert property ($rose(pins.hv_en) |-> pins.vdd_en
        && pins.chip_select_n && !pins.reset_n) else $error("drive early");
    rst_release_a: assert property ($rose(pins.reset_n) |->
        hv_cnt >= HV_SETTLE + 125) else $error("release early");
    show_wait_a: assert property ($rose(shown) |-> up_cnt > DISP_ON_WAIT)
        else $error("shown early");
    hv_off_a: assert property ($fell(pins.hv_en) |-> !pins.reset_n
        && pins.chip_select_n && lo_cnt >= 125) else $error("drive off early");
    link_select_a: assert property ($rose(serial_clock_pin)
        && !serial_clock_oe_n |-> !pins.chip_select_n) else $error("no cs");
    shown_power_a: assert property (shown |-> pins.vdd_en && pins.hv_en
        && pins.reset_n) else $error("shown unpowered");
endmodule
bind display_power_init_sequencer seq_properties #(.VDD_WAIT(VDD_WAIT),
    .HV_SETTLE(HV_SETTLE), .DISP_ON_WAIT(DISP_ON_WAIT)) i_seq_properties (
    .clk(clk), .rst(rst), .pins(pins), .cmd_data_select(cmd_data_select),
    .serial_clock_pin(serial_clock_pin), .shown(shown),
    .serial_clock_oe_n(serial_clock_oe_n),
    .serial_data_oe_n(serial_data_oe_n));
`default_nettype wire

/* panel.sv */
`timescale 1ns/1ps
`default_nettype none
module panel (
    input wire logic sck,
    input wire logic sdi,
    input wire logic cds,
    input wire logic cs_n,
    input wire logic rst_n
);
    logic [15:0] val [256];
    logic [7:0] first [2];
    logic [7:0] cur = 8'h00;
    logic [7:0] sh = 8'h00;
    int nb = 0;
    int ncmd = 0;
    int nimg = 0;
    int npar = 0;
    // Only the SPI target is modelled; bits land MSB first on rising clock.
    always @(posedge sck or posedge cs_n) begin
        if (cs_n || !rst_n) begin
            nb = 0;
        end else begin
            sh = {sh[6:0], sdi};
            nb = nb + 1;
        end
        if (nb == 8 && !cds) begin
            cur = sh;
            val[cur] = 16'h0000;
            if (ncmd < 2) first[ncmd] = sh;
            ncmd = ncmd + 1;
            if (sh == 8'h08) nimg = 0;
        end else if (nb == 8) begin
            val[cur] = {val[cur][7:0], sh};
            npar = npar + 1;
            if (cur == 8'h08) nimg = nimg + 1;
        end
        if (nb == 8) nb = 0;
    end
endmodule
`default_nettype wire

/* display_power_init_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module display_power_init_sequencer_tb;
    import oled_ctl_pkg::*;
    localparam logic [23:0] EXP [20] = '{24'h1A0004, 24'h1D0000,
        24'h090000, 24'h30003B, 24'h32001F, 24'h380000, 24'h390000,
        24'h340000, 24'h350007, 24'h360000, 24'h37001F, 24'h100000,
        24'h160000, 24'h120050, 24'h180003, 24'h440002, 24'h480003,
        24'h170000, 24'h130000, 24'h1C0000};
    logic clk = 0;
    logic rst = 1;
    op_t op = OP_NONE;
    logic op_valid = 0;
    logic with_image = 0;
    logic [7:0] img_byte = 8'h00;
    logic op_ready, op_error, img_req, cds, sck, sck_oe_n, sda, sda_oe_n;
    logic powered, shown, sck_w, sda_w;
    logic i2c = 0;
    logic [27:0] cap = '0;
    logic [23:0] e;
    logic [15:0] v;
    power_pins_t pins;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    // Released lines rest high on the board pull-ups.
    assign sck_w = sck_oe_n ? 1'b1 : sck;
    // An I2C target acknowledges by pulling data low in each released slot.
    assign sda_w = sda_oe_n ? !(i2c && !sck_oe_n) : sda;
    display_power_init_sequencer #(.VDD_WAIT(100), .HV_SETTLE(50),
        .DISP_ON_WAIT(200)) i_display_power_init_sequencer (.clk, .rst, .op,
        .op_valid, .with_image, .img_byte, .host_if_select(i2c),
        .serial_clock_in(sck_w), .serial_data_in(sda_w), .op_ready,
        .op_error, .img_req, .pins, .cmd_data_select(cds), .powered, .shown,
        .serial_clock_pin(sck), .serial_clock_oe_n(sck_oe_n),
        .serial_data_pin(sda), .serial_data_oe_n(sda_oe_n));
    panel i_panel (.sck(sck_w), .sdi(sda_w), .cds(cds),
        .cs_n(pins.chip_select_n), .rst_n(pins.reset_n));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(negedge clk) begin
        if (img_req) img_byte <= img_byte + 8'h01;
    end
    always @(posedge sck_w) begin
        if (i2c) cap <= {cap[26:0], sda_w};
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d bad %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Valid is held past the taking edge, then the bench waits for idle.
    task automatic req(input op_t o, input logic img);
        @(negedge clk);
        op = o;
        with_image = img;
        op_valid = 1'b1;
        repeat (3) @(negedge clk);
        op_valid = 1'b0;
        repeat (2) @(negedge clk);
        while (op_ready !== 1'b1) @(negedge clk);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        check(16'({pins.reset_n, pins.chip_select_n, cds, sck_oe_n,
            sda_oe_n}), 16'h0003);
        rst = 0;
        repeat (2) @(negedge clk);
        req(OP_DISPLAY_ON, 1'b0);
        check(16'({powered, shown}), 16'h0000);
        req(OP_POWER_UP, 1'b0);
        check(16'({pins, powered}), 16'h001F);
        $display("test power_up done");
        req(OP_INIT, 1'b0);
        check({i_panel.first[0], i_panel.first[1]}, 16'h0214);
        check(16'(i_panel.npar), 16'h0018);
        for (int i = 0; i < 20; i++) begin
            e = EXP[i];
            v = i_panel.val[e[23:16]];
            check(v, e[15:0]);
        end
        check(16'(shown), 16'h0000);
        $display("test init done");
        req(OP_DISPLAY_ON, 1'b1);
        check(16'({shown, i_panel.val[8'h02][0], i_panel.val[8'h14][0]}),
            16'h0006);
        check(16'(i_panel.nimg), 16'h0100);
        req(OP_DISPLAY_OFF, 1'b0);
        check(16'({shown, i_panel.val[8'h02][0], i_panel.val[8'h14][0]}),
            16'h0001);
        $display("test display done");
        req(op_t'(3'h6), 1'b0);
        check(16'(op_error), 16'h0001);
        i2c = 1'b1;
        req(OP_DISPLAY_OFF, 1'b0);
        check(16'({cap[27:21], cap[9:2]}), 16'h3001);
        check(16'(op_error), 16'h0000);
        i2c = 1'b0;
        $display("test i2c done");
        req(OP_POWER_DOWN, 1'b0);
        check(16'({pins, powered, cds}), 16'h0000);
        $display("test power_down done");
        end_sim();
    end
endmodule
`default_nettype wire
